// File: logic/cd_diag_pkg.sv
// Purpose: Shared constants and carrier types for the cable diagnostic register bank.
// Assumes: APB with 32-bit data; each 16-bit register sits in the low half of one word.
// Notes: Register indices are word indices; the byte address is four times the index.
package cd_diag_pkg;

  localparam int unsigned CD_ADDR_W = 12;
  localparam int unsigned CD_IDX_W = 10;

  // Register word indices.
  localparam logic [9:0] CD_IDX_ACTIVE_LINK_CABLE_DIAG = 10'h155;
  localparam logic [9:0] CD_IDX_MAIN = 10'h170;
  localparam logic [9:0] CD_IDX_PULSE = 10'h171;
  localparam logic [9:0] CD_IDX_LISTEN = 10'h173;
  localparam logic [9:0] CD_IDX_THRESH = 10'h177;
  localparam logic [9:0] CD_IDX_LOC12 = 10'h180;
  localparam logic [9:0] CD_IDX_LOC34 = 10'h181;
  localparam logic [9:0] CD_IDX_LOC5R1 = 10'h182;
  localparam logic [9:0] CD_IDX_CMD = 10'h1A0;
  localparam logic [9:0] CD_IDX_IRQ_STAT = 10'h1A1;
  localparam logic [9:0] CD_IDX_IRQ_EN = 10'h1A2;
  localparam logic [9:0] CD_IDX_IRQ_CLR = 10'h1A3;

  // Reset values of the writable registers, reserved bits included.
  localparam logic [15:0] CD_RST_ACTIVE_LINK_CABLE_DIAG = 16'h0001;
  localparam logic [15:0] CD_RST_MAIN = 16'h0E52;
  localparam logic [15:0] CD_RST_PULSE = 16'hC85C;
  localparam logic [15:0] CD_RST_LISTEN = 16'hFF1E;
  localparam logic [15:0] CD_RST_THRESH = 16'h189B;

  // Field positions.
  localparam int unsigned CD_ACTIVE_LINK_CABLE_DIAG_START_BIT = 15;
  localparam int unsigned CD_ACTIVE_LINK_CABLE_DIAG_PEND_BIT = 12;
  localparam int unsigned CD_ACTIVE_LINK_CABLE_DIAG_SUM_LSB = 4;
  localparam int unsigned CD_MAIN_CROSS_DIS_BIT = 14;
  localparam int unsigned CD_MAIN_TX_SKIP_BIT = 13;
  localparam int unsigned CD_MAIN_RX_SKIP_BIT = 12;
  localparam int unsigned CD_MAIN_AVG_LSB = 8;
  localparam int unsigned CD_PULSE_LSB = 0;
  localparam int unsigned CD_LISTEN_LSB = 8;
  localparam int unsigned CD_THRESH_LSB = 8;
  localparam int unsigned CD_CMD_TDR_GO_BIT = 0;
  localparam int unsigned CD_CMD_TDR_BUSY_BIT = 1;

  localparam logic [2:0] CD_AVG_RESERVED = 3'h7;

  // Interrupt event bit positions.
  localparam int unsigned CD_EV_ACTIVE_LINK_CABLE_DIAG_DONE = 0;
  localparam int unsigned CD_EV_TDR_DONE = 1;
  localparam int unsigned CD_EV_REFUSED = 2;
  localparam int unsigned CD_EV_N = 3;

  typedef enum logic [0:0] {
    CD_RUN_IDLE = 1'b0,
    CD_RUN_BUSY = 1'b1
  } cd_run_e;

  typedef struct packed {
    logic cross_en;
    logic tx_pair_skip;
    logic rx_pair_skip;
    logic [6:0] avg_cycles;
    logic [3:0] pulse_self_reflection;
    logic [7:0] listen_duration;
    logic [4:0] short_threshold;
  } cd_cfg_s;

  typedef struct packed {
    logic [4:0][7:0] tx_peak;
    logic [7:0] rx_peak1;
  } cd_tdr_res_s;

endpackage

// File: logic/cd_diag_reg_bank.sv
// Purpose: APB register bank for active-link diagnostics and the TDR engine.
// Assumes: The diagnostic engines run on clk_sys; their strobes need no synchroniser.
// Notes: Zero wait states; pslverr answers an unmapped address.
//
// Overview of operation
// RULE_01 - Writing one starts active test, self-clears
// RULE_02 - Status bit reads one while test runs
// RULE_03 - Cross bit zero watches opposite pair
// RULE_04 - Transmit bypass bit one skips transmit pair
// RULE_05 - Receive bypass bit one skips receive pair
// RULE_06 - Averaging code selects 1 to 64 cycles
// RULE_07 - Four-bit pulse self-reflection field, reset 1100
// RULE_08 - Eight-bit listen duration field, reset all ones
// RULE_09 - Five-bit short-cable threshold, reset 11000
// RULE_10 - Five transmit peak locations, read only
// RULE_11 - First receive peak in upper byte
// RULE_12 - Software converts peak values into distance
// RULE_13 - Results ignore writes, hold, reset zero
// RULE_14 - Software rewrites reserved fields with reset values
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns

module cd_diag_reg_bank
  import cd_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cd_diag_pkg::CD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic active_link_cable_diag_go,
  input wire logic active_link_cable_diag_done,
  input wire logic [7:0] active_link_cable_diag_sum,
  output logic tdr_go,
  output cd_diag_pkg::cd_cfg_s tdr_cfg,
  input wire logic tdr_done,
  input wire cd_diag_pkg::cd_tdr_res_s tdr_result,
  output logic irq
);
  import cd_diag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  wire setup = psel & ~penable;
  wire access = psel & penable & pready_reg;
  wire wr = access & pwrite;
  wire [CD_IDX_W-1:0] idx = paddr[CD_ADDR_W-1:2];
  wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wd = pwdata[15:0];

  wire hit_active_link_cable_diag = (idx == CD_IDX_ACTIVE_LINK_CABLE_DIAG);
  wire hit_main = (idx == CD_IDX_MAIN);
  wire hit_pulse = (idx == CD_IDX_PULSE);
  wire hit_listen = (idx == CD_IDX_LISTEN);
  wire hit_thresh = (idx == CD_IDX_THRESH);
  wire hit_loc12 = (idx == CD_IDX_LOC12);
  wire hit_loc34 = (idx == CD_IDX_LOC34);
  wire hit_loc5r1 = (idx == CD_IDX_LOC5R1);
  wire hit_cmd = (idx == CD_IDX_CMD);
  wire hit_istat = (idx == CD_IDX_IRQ_STAT);
  wire hit_ien = (idx == CD_IDX_IRQ_EN);
  wire hit_iclr = (idx == CD_IDX_IRQ_CLR);
  wire map_hit = hit_active_link_cable_diag | hit_main | hit_pulse | hit_listen | hit_thresh | hit_loc12
    | hit_loc34 | hit_loc5r1 | hit_cmd | hit_istat | hit_ien | hit_iclr;

  ////////////////////////////////////////////////////////////////////////////////
  // Writable register storage.

  logic [3:0] active_link_cable_diag_rsvd_reg;
  logic [3:0] active_link_cable_diag_rsvd_next;
  logic [14:0] main_reg;
  logic [14:0] main_next;
  logic [15:0] pulse_reg;
  logic [15:0] pulse_next;
  logic [15:0] listen_reg;
  logic [15:0] listen_next;
  logic [15:0] thresh_reg;
  logic [15:0] thresh_next;
  logic [CD_EV_N-1:0] ien_reg;
  logic [CD_EV_N-1:0] ien_next;

  wire [15:0] main_merged = ({1'b0, main_reg} & ~wmask) | (wd & wmask);
  wire [2:0] avg_wr_code = main_merged[CD_MAIN_AVG_LSB +: 3];
  wire avg_refused = wr & hit_main & (avg_wr_code == CD_AVG_RESERVED);

  assign active_link_cable_diag_rsvd_next = (wr & hit_active_link_cable_diag) ?
    ((active_link_cable_diag_rsvd_reg & ~wmask[3:0]) | (wd[3:0] & wmask[3:0])) : active_link_cable_diag_rsvd_reg;
  // A reserved averaging code is refused; the rest of the word still lands.
  assign main_next = !(wr & hit_main) ? main_reg :
    avg_refused ? {main_merged[14:11], main_reg[10:8], main_merged[7:0]} :
    main_merged[14:0]; // see RULE_06
  assign pulse_next = (wr & hit_pulse) ? ((pulse_reg & ~wmask) | (wd & wmask)) :
    pulse_reg; // see RULE_07
  assign listen_next = (wr & hit_listen) ? ((listen_reg & ~wmask) | (wd & wmask)) :
    listen_reg; // see RULE_08
  assign thresh_next = (wr & hit_thresh) ? ((thresh_reg & ~wmask) | (wd & wmask)) :
    thresh_reg; // see RULE_09
  assign ien_next = (wr & hit_ien & pstrb[0]) ? wd[CD_EV_N-1:0] : ien_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_link_cable_diag_rsvd_reg <= CD_RST_ACTIVE_LINK_CABLE_DIAG[3:0];
    end else begin
      active_link_cable_diag_rsvd_reg <= active_link_cable_diag_rsvd_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      main_reg <= CD_RST_MAIN[14:0];
    end else begin
      main_reg <= main_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pulse_reg <= CD_RST_PULSE;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      listen_reg <= CD_RST_LISTEN;
    end else begin
      listen_reg <= listen_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      thresh_reg <= CD_RST_THRESH;
    end else begin
      thresh_reg <= thresh_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ien_reg <= '0;
    end else begin
      ien_reg <= ien_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Active-link diagnostic sequencing.

  cd_run_e active_link_cable_diag_state_reg;
  cd_run_e active_link_cable_diag_state_next;
  logic active_link_cable_diag_start_reg;
  logic active_link_cable_diag_start_next;
  logic [7:0] active_link_cable_diag_sum_reg;
  logic [7:0] active_link_cable_diag_sum_next;

  // The start bit is high for one cycle only; that cycle is the go pulse.
  assign active_link_cable_diag_start_next = wr & hit_active_link_cable_diag & wmask[CD_ACTIVE_LINK_CABLE_DIAG_START_BIT]
    & wd[CD_ACTIVE_LINK_CABLE_DIAG_START_BIT]; // see RULE_01
  wire active_link_cable_diag_finish = (active_link_cable_diag_state_reg == CD_RUN_BUSY) & active_link_cable_diag_done & ~active_link_cable_diag_start_reg;

  always_comb begin
    case (active_link_cable_diag_state_reg)
      CD_RUN_IDLE: begin
        active_link_cable_diag_state_next = active_link_cable_diag_start_reg ? CD_RUN_BUSY : CD_RUN_IDLE; // see RULE_02
      end
      CD_RUN_BUSY: begin
        active_link_cable_diag_state_next = active_link_cable_diag_finish ? CD_RUN_IDLE : CD_RUN_BUSY; // see RULE_02
      end
      default: begin
        active_link_cable_diag_state_next = CD_RUN_IDLE;
      end
    endcase
  end

  assign active_link_cable_diag_sum_next = active_link_cable_diag_finish ? active_link_cable_diag_sum : active_link_cable_diag_sum_reg; // see RULE_13

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_link_cable_diag_state_reg <= CD_RUN_IDLE;
    end else begin
      active_link_cable_diag_state_reg <= active_link_cable_diag_state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_link_cable_diag_start_reg <= 1'b0;
    end else begin
      active_link_cable_diag_start_reg <= active_link_cable_diag_start_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active_link_cable_diag_sum_reg <= '0;
    end else begin
      active_link_cable_diag_sum_reg <= active_link_cable_diag_sum_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // TDR run control and results.

  cd_run_e tdr_state_reg;
  cd_run_e tdr_state_next;
  logic tdr_go_reg;
  logic tdr_go_next;
  cd_tdr_res_s tdr_res_reg;
  cd_tdr_res_s tdr_res_next;
  cd_cfg_s cfg_reg;
  cd_cfg_s cfg_next;

  wire tdr_go_req = wr & hit_cmd & pstrb[0] & wd[CD_CMD_TDR_GO_BIT];
  // A start request while a run is under way is refused.
  wire tdr_refused = tdr_go_req & (tdr_state_reg == CD_RUN_BUSY);
  assign tdr_go_next = tdr_go_req & (tdr_state_reg == CD_RUN_IDLE);
  wire tdr_finish = (tdr_state_reg == CD_RUN_BUSY) & tdr_done;

  always_comb begin
    case (tdr_state_reg)
      CD_RUN_IDLE: begin
        tdr_state_next = tdr_go_next ? CD_RUN_BUSY : CD_RUN_IDLE;
      end
      CD_RUN_BUSY: begin
        tdr_state_next = tdr_finish ? CD_RUN_IDLE : CD_RUN_BUSY;
      end
      default: begin
        tdr_state_next = CD_RUN_IDLE;
      end
    endcase
  end

  assign tdr_res_next = tdr_finish ? tdr_result : tdr_res_reg; // see RULE_10 RULE_11 RULE_13

  assign cfg_next.cross_en = ~main_reg[CD_MAIN_CROSS_DIS_BIT]; // see RULE_03
  assign cfg_next.tx_pair_skip = main_reg[CD_MAIN_TX_SKIP_BIT]; // see RULE_04
  assign cfg_next.rx_pair_skip = main_reg[CD_MAIN_RX_SKIP_BIT]; // see RULE_05
  assign cfg_next.avg_cycles = 7'h01 << main_reg[CD_MAIN_AVG_LSB +: 3]; // see RULE_06
  assign cfg_next.pulse_self_reflection = pulse_reg[CD_PULSE_LSB +: 4]; // see RULE_07
  assign cfg_next.listen_duration = listen_reg[CD_LISTEN_LSB +: 8]; // see RULE_08
  assign cfg_next.short_threshold = thresh_reg[CD_THRESH_LSB +: 5]; // see RULE_09

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tdr_state_reg <= CD_RUN_IDLE;
    end else begin
      tdr_state_reg <= tdr_state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tdr_go_reg <= 1'b0;
    end else begin
      tdr_go_reg <= tdr_go_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tdr_res_reg <= '0;
    end else begin
      tdr_res_reg <= tdr_res_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.

  logic [CD_EV_N-1:0] istat_reg;
  logic [CD_EV_N-1:0] istat_next;
  logic irq_reg;
  wire irq_next = |(istat_reg & ien_reg);

  wire [CD_EV_N-1:0] ev;
  wire [CD_EV_N-1:0] iclr = (wr & hit_iclr & pstrb[0]) ? wd[CD_EV_N-1:0] : '0;

  assign ev[CD_EV_ACTIVE_LINK_CABLE_DIAG_DONE] = active_link_cable_diag_finish;
  assign ev[CD_EV_TDR_DONE] = tdr_finish;
  assign ev[CD_EV_REFUSED] = avg_refused | tdr_refused;

  // An event in the cycle of its clear keeps the bit set.
  genvar gi;
  generate
    for (gi = 0; gi < CD_EV_N; gi++) begin : g_istat
      assign istat_next[gi] = ev[gi] | (istat_reg[gi] & ~iclr[gi]);
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      istat_reg <= '0;
    end else begin
      istat_reg <= istat_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back and APB answer.

  wire [15:0] rd_active_link_cable_diag = {active_link_cable_diag_start_reg, 2'b00, (active_link_cable_diag_state_reg == CD_RUN_BUSY),
    active_link_cable_diag_sum_reg, active_link_cable_diag_rsvd_reg}; // see RULE_01 RULE_02
  wire [15:0] rd_loc12 = {tdr_res_reg.tx_peak[1], tdr_res_reg.tx_peak[0]}; // see RULE_10
  wire [15:0] rd_loc34 = {tdr_res_reg.tx_peak[3], tdr_res_reg.tx_peak[2]}; // see RULE_10
  wire [15:0] rd_loc5r1 = {tdr_res_reg.rx_peak1, tdr_res_reg.tx_peak[4]}; // see RULE_11
  wire [15:0] rd_cmd = {14'h0000, (tdr_state_reg == CD_RUN_BUSY), 1'b0};

  wire [15:0] rd_data =
    hit_active_link_cable_diag ? rd_active_link_cable_diag :
    hit_main ? {1'b0, main_reg} :
    hit_pulse ? pulse_reg :
    hit_listen ? listen_reg :
    hit_thresh ? thresh_reg :
    hit_loc12 ? rd_loc12 :
    hit_loc34 ? rd_loc34 :
    hit_loc5r1 ? rd_loc5r1 :
    hit_cmd ? rd_cmd :
    hit_istat ? {13'h0000, istat_reg} :
    hit_ien ? {13'h0000, ien_reg} :
    16'h0000;

  wire rd_setup = setup & ~pwrite;
  wire [31:0] prdata_next = rd_setup ? {16'h0000, rd_data} : prdata_reg;

  // Read data is captured in the setup cycle and held through the access cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup & ~map_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign active_link_cable_diag_go = active_link_cable_diag_start_reg;
  assign tdr_go = tdr_go_reg;
  assign tdr_cfg = cfg_reg;
  assign irq = irq_reg;

endmodule // cd_diag_reg_bank

// File: tb/cd_cable_model.sv
// Purpose: Stand-in for the diagnostic engines and the cable under test.
// Assumes: Runs on the bank clock; answers lag cycles after each start pulse.
// Notes: Result lines toggle outside the done cycle, so stale data never looks valid.
`timescale 1ns/1ns
module cd_cable_model
  import cd_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic active_link_cable_diag_go,
  input wire logic tdr_go,
  input wire logic [3:0] lag,
  input wire logic [7:0] sum_in,
  input wire cd_diag_pkg::cd_tdr_res_s res_in,
  output logic active_link_cable_diag_done = 1'b0,
  output logic [7:0] active_link_cable_diag_sum = 8'h00,
  output logic tdr_done = 1'b0,
  output cd_diag_pkg::cd_tdr_res_s tdr_result = '0
);
  int a_n = 0;
  int t_n = 0;
  always @(posedge clk_sys) begin
    a_n <= active_link_cable_diag_go ? int'(lag) : a_n - int'(a_n != 0);
    t_n <= tdr_go ? int'(lag) : t_n - int'(t_n != 0);
    active_link_cable_diag_done <= a_n == 1;
    tdr_done <= t_n == 1;
    active_link_cable_diag_sum <= a_n == 1 ? sum_in : ~active_link_cable_diag_sum;
    tdr_result <= t_n == 1 ? res_in : ~tdr_result;
  end
endmodule // cd_cable_model

// File: tb/cd_diag_sva.sv
// Purpose: Port-level checker for the diagnostic register bank.
// Assumes: Single clock domain with synchronous reset.
// Notes: Configuration output trails a register write by two cycles.
`timescale 1ns/1ns
module cd_diag_sva
  import cd_diag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cd_diag_pkg::CD_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic active_link_cable_diag_go,
  input wire logic tdr_go,
  input wire cd_diag_pkg::cd_cfg_s tdr_cfg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire wr = psel && penable && pready && pwrite;
  wire [9:0] ix = paddr[11:2];
  wire st_w = wr && ix == CD_IDX_ACTIVE_LINK_CABLE_DIAG && pstrb[1] && pwdata[15];
  //////////////////////////////
  sequence s_start; st_w; endsequence
  sequence s_main; wr && ix == CD_IDX_MAIN && pstrb[1] && pwdata[10:8] != 3'h7; endsequence
  property p_start; s_start |=> active_link_cable_diag_go ##1 !active_link_cable_diag_go; endproperty
  property p_nostart; wr && ix == CD_IDX_ACTIVE_LINK_CABLE_DIAG && !pwdata[15] |=> !active_link_cable_diag_go; endproperty
  property p_go_src; active_link_cable_diag_go |-> $past(st_w); endproperty
  property p_cross; s_main |=> ##1 tdr_cfg.cross_en != $past(pwdata[14], 2); endproperty
  property p_txskip; s_main |=> ##1 tdr_cfg.tx_pair_skip == $past(pwdata[13], 2); endproperty
  property p_rxskip; s_main |=> ##1 tdr_cfg.rx_pair_skip == $past(pwdata[12], 2); endproperty
  property p_avg; s_main |=> ##1 tdr_cfg.avg_cycles == 7'h01 << $past(pwdata[10:8], 2); endproperty
  property p_pulse;
    wr && ix == CD_IDX_PULSE && pstrb[0] |=> ##1
      tdr_cfg.pulse_self_reflection == $past(pwdata[3:0], 2);
  endproperty
  property p_tdrgo;
    tdr_go |-> $past(wr && ix == CD_IDX_CMD && pstrb[0] && pwdata[0]) ##1 !tdr_go;
  endproperty
  a_tdrgo: assert property (p_tdrgo) else $error("run start pulse wrong");
  a_start: assert property (p_start) else $error("start pulse wrong");
  a_nostart: assert property (p_nostart) else $error("start on zero");
  a_go_src: assert property (p_go_src) else $error("go without write");
  a_cross: assert property (p_cross) else $error("cross mode wrong");
  a_txskip: assert property (p_txskip) else $error("tx skip wrong");
  a_rxskip: assert property (p_rxskip) else $error("rx skip wrong");
  a_avg: assert property (p_avg) else $error("average count wrong");
  a_pulse: assert property (p_pulse) else $error("pulse field wrong");
endmodule // cd_diag_sva
bind cd_diag_reg_bank cd_diag_sva sva_u (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .active_link_cable_diag_go, .tdr_go, .tdr_cfg);

// File: tb/tb_cd_diag_reg_bank.sv
// Purpose: Self-checking bench for the diagnostic register bank.
// Assumes: APB slave answers after setup; engine stand-in answers after lag cycles.
// Notes: The driver queues expected answers and a monitor compares them.
`timescale 1ns/1ns
module tb_cd_diag_reg_bank;
  import cd_diag_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, x;
  logic [3:0] pstrb = 4'h0, lag = 4'h3;
  logic pready, pslverr, active_link_cable_diag_go, active_link_cable_diag_done, tdr_go, tdr_done, irq;
  logic [7:0] active_link_cable_diag_sum, sum_in = 8'h00;
  cd_cfg_s tdr_cfg;
  cd_tdr_res_s tdr_result, res_in = '0;
  int mismatches = 0, checks = 0;
  int unsigned st = 85822;
  logic [17:0] exq[$], q;
  logic [15:0] v;
  logic [31:0] cfg0 = {5'h00, 1'h1, 2'h0, 7'h40, 4'hC, 8'hFF, 5'h18};
  logic [9:0] ri[9] = '{CD_IDX_ACTIVE_LINK_CABLE_DIAG, CD_IDX_MAIN, CD_IDX_PULSE, CD_IDX_LISTEN, CD_IDX_THRESH,
    CD_IDX_LOC12, CD_IDX_LOC34, CD_IDX_LOC5R1, CD_IDX_IRQ_STAT};
  logic [15:0] rv[9] = '{16'h0001, 16'h0E52, 16'hC85C, 16'hFF1E, 16'h189B, 16'h0, 16'h0,
    16'h0, 16'h0};
  cd_diag_reg_bank dut_u (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .active_link_cable_diag_go, .active_link_cable_diag_done, .active_link_cable_diag_sum, .tdr_go, .tdr_cfg, .tdr_done,
    .tdr_result, .irq);
  cd_cable_model cab_u (.clk_sys, .active_link_cable_diag_go, .tdr_go, .lag, .sum_in, .res_in, .active_link_cable_diag_done,
    .active_link_cable_diag_sum, .tdr_done, .tdr_result);
  initial forever #5 clk_sys = ~clk_sys;
  //////////////////////////////
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    // Expected answers that never arrived count as mismatches.
    mismatches += exq.size();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [9:0] ix, input logic [15:0] d,
      input logic [3:0] s, input logic [15:0] e, input logic er = 1'b0);
    exq.push_back({w, er, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= (rnd() << 16) | {16'h0, d};
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && exq.size() > 0) begin
      q = exq.pop_front();
      chk("pslverr", {31'h0, q[16]}, {31'h0, pslverr});
      if (!q[17]) chk("prdata", {16'h0, q[15:0]}, prdata);
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end
  //////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (ri[i]) xfer(0, ri[i], 0, 0, rv[i]);
    chk("cfg", cfg0, {5'h00, tdr_cfg});
    for (int i = 5; i < 8; i++) begin
      xfer(1, ri[i], 16'hFFFF, 4'hF, 0);
      xfer(0, ri[i], 0, 0, 0);
    end
    xfer(1, 10'h3FF, 16'hFFFF, 4'hF, 0, 1);
    xfer(0, 10'h3FF, 0, 0, 0, 1);
    for (int c = 0; c < 8; c++) begin
      x = rnd();
      v = {1'b0, x[2:0], 1'b1, c[2:0], 8'h52};
      xfer(1, CD_IDX_MAIN, v, 4'h3, 0);
      if (c == 7) v[10:8] = 3'h6;
      xfer(0, CD_IDX_MAIN, 0, 0, v);
    end
    xfer(0, CD_IDX_IRQ_STAT, 0, 0, 16'h0004);
    xfer(1, CD_IDX_IRQ_CLR, 16'h0007, 4'h1, 0);
    x = rnd();
    xfer(1, CD_IDX_PULSE, {12'hC85, x[3:0]}, 4'h3, 0);
    xfer(0, CD_IDX_PULSE, 0, 0, {12'hC85, x[3:0]});
    xfer(1, CD_IDX_LISTEN, {x[15:8], 8'h1E}, 4'h3, 0);
    xfer(1, CD_IDX_THRESH, {3'h0, x[20:16], 8'h9B}, 4'h3, 0);
    xfer(0, CD_IDX_THRESH, 0, 0, {3'h0, x[20:16], 8'h9B});
    chk("listen", {24'h0, x[15:8]}, {24'h0, tdr_cfg.listen_duration});
    chk("thresh", {27'h0, x[20:16]}, {27'h0, tdr_cfg.short_threshold});
    xfer(1, CD_IDX_IRQ_EN, 16'h0007, 4'h1, 0);
    lag <= 4'h3 + {1'b0, x[26:24]};
    sum_in <= x[31:24];
    xfer(1, CD_IDX_ACTIVE_LINK_CABLE_DIAG, 16'h8001, 4'h3, 0);
    xfer(0, CD_IDX_ACTIVE_LINK_CABLE_DIAG, 0, 0, 16'h1001);
    repeat (12) @(posedge clk_sys);
    xfer(1, CD_IDX_ACTIVE_LINK_CABLE_DIAG, 16'h0001, 4'h3, 0);
    xfer(0, CD_IDX_ACTIVE_LINK_CABLE_DIAG, 0, 0, {4'h0, x[31:24], 4'h1});
    chk("irq", 32'h1, {31'h0, irq});
    xfer(1, CD_IDX_IRQ_EN, 16'h0000, 4'h1, 0);
    xfer(0, CD_IDX_IRQ_STAT, 0, 0, 16'h0001);
    chk("irq", 32'h0, {31'h0, irq});
    xfer(1, CD_IDX_IRQ_CLR, 16'h0007, 4'h1, 0);
    xfer(1, CD_IDX_IRQ_EN, 16'h0007, 4'h1, 0);
    lag <= 4'hF;
    res_in <= {rnd(), x[15:0]};
    xfer(1, CD_IDX_CMD, 16'h0001, 4'h1, 0);
    xfer(0, CD_IDX_CMD, 0, 0, 16'h0002);
    xfer(1, CD_IDX_CMD, 16'h0001, 4'h1, 0);
    repeat (20) @(posedge clk_sys);
    xfer(0, CD_IDX_IRQ_STAT, 0, 0, 16'h0006);
    xfer(0, CD_IDX_LOC12, 0, 0, {res_in.tx_peak[1], res_in.tx_peak[0]});
    xfer(0, CD_IDX_LOC34, 0, 0, {res_in.tx_peak[3], res_in.tx_peak[2]});
    xfer(0, CD_IDX_LOC5R1, 0, 0, {res_in.rx_peak1, res_in.tx_peak[4]});
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    xfer(0, CD_IDX_LOC5R1, 0, 0, 16'h0000);
    chk("cfg", cfg0, {5'h00, tdr_cfg});
    chk("irq", 32'h0, {31'h0, irq});
    close_out();
  end
endmodule // tb_cd_diag_reg_bank
